// ---- core/xbar_cfg.svh ----
`ifndef XBAR_CFG_SVH
`define XBAR_CFG_SVH

// Register addresses on the special-function bus
`define XBAR_ADDR_ENABLE_A  8'he1
`define XBAR_ADDR_ENABLE_B  8'he2
`define XBAR_RESET_VALUE    8'h00

// Fields of crossbar_enable_a
`define XBAR_A_CMP_ZERO     7
`define XBAR_A_CNT_CLK      6
`define XBAR_A_CEX_HI       5
`define XBAR_A_CEX_LO       3
`define XBAR_A_UART_FIRST   2
`define XBAR_A_SPI          1
`define XBAR_A_SMB          0

// Fields of crossbar_enable_b
`define XBAR_B_SYSCK        7
`define XBAR_B_CAP_TWO      6
`define XBAR_B_TMR_TWO      5
`define XBAR_B_IRQ_ONE      4
`define XBAR_B_TMR_ONE      3
`define XBAR_B_IRQ_ZERO     2
`define XBAR_B_TMR_ZERO     1
`define XBAR_B_CMP_ONE      0

// Enables that arrive from the third register
`define XBAR_EXT_UART_TWO   0
`define XBAR_EXT_TMR_FOUR   1
`define XBAR_EXT_CAP_FOUR   2
`define XBAR_EXT_CONVERT    3

// Highest legal compare-output count
`define XBAR_CEX_MAX        3'h5

// Function slots in priority order
`define XBAR_NPINS          32
`define XBAR_SLOT_TX0       0
`define XBAR_SLOT_RX0       1
`define XBAR_SLOT_SCK       2
`define XBAR_SLOT_MISO      3
`define XBAR_SLOT_MOSI      4
`define XBAR_SLOT_NSS       5
`define XBAR_SLOT_SDA       6
`define XBAR_SLOT_SCL       7
`define XBAR_SLOT_TX1       8
`define XBAR_SLOT_RX1       9
`define XBAR_SLOT_CMP_OUT0  10
`define XBAR_SLOT_CMP_OUT1  11
`define XBAR_SLOT_CMP_OUT2  12
`define XBAR_SLOT_CMP_OUT3  13
`define XBAR_SLOT_CMP_OUT4  14
`define XBAR_SLOT_CNT_CLK   15
`define XBAR_SLOT_CMP_ZERO  16
`define XBAR_SLOT_CMP_ONE   17
`define XBAR_SLOT_TMR_ZERO  18
`define XBAR_SLOT_IRQ_ZERO  19
`define XBAR_SLOT_TMR_ONE   20
`define XBAR_SLOT_IRQ_ONE   21
`define XBAR_SLOT_TMR_TWO   22
`define XBAR_SLOT_CAP_TWO   23
`define XBAR_SLOT_TMR_FOUR  24
`define XBAR_SLOT_CAP_FOUR  25
`define XBAR_SLOT_SYSCK     26
`define XBAR_SLOT_CNV       27
`define XBAR_NSLOT          28
`define XBAR_NO_SLOT        5'h1f

`endif

// ---- core/xbar_pkg.sv ----
`default_nettype none
package xbar_pkg;
    `include "xbar_cfg.svh"

    // Special-function bus request
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } xbar_sfr_req_t;

    // Stored crossbar configuration
    typedef struct packed {
        logic [7:0] enable_a;
        logic [7:0] enable_b;
        logic [7:0] rdata;
    } xbar_state_t;

    // Per-pin routing result
    typedef struct packed {
        logic [`XBAR_NPINS-1:0] assigned;
        logic [`XBAR_NPINS-1:0] force_input;
    } xbar_pinmap_t;
endpackage
`default_nettype wire

// ---- core/xbar_alloc.sv ----
`default_nettype none
`include "xbar_cfg.svh"
// Priority allocator: each enabled slot takes the next free non-skipped pin
module xbar_alloc
    import xbar_pkg::*;
(
    // Requests and skips
    input  wire logic [`XBAR_NSLOT-1:0] slot_req,
    input  wire logic [`XBAR_NPINS-1:0] pin_skip,
    // Result: slot index per pin, or none
    output logic [`XBAR_NPINS*5-1:0]    pin_slot,
    output logic [`XBAR_NPINS-1:0]      pin_used
);
    // Purely combinational; a ripple search is fine at 25 MHz
    always_comb
    begin
        logic [`XBAR_NPINS-1:0] taken;
        logic                   found;
        taken    = '0;
        found    = 1'b0;
        pin_slot = {`XBAR_NPINS{`XBAR_NO_SLOT}};
        pin_used = '0;
        for (int s = 0; s < `XBAR_NSLOT; s++)
        begin
            found = 1'b0;
            for (int p = 0; p < `XBAR_NPINS; p++)
            begin
                if (slot_req[s] && !found && !pin_skip[p] && !taken[p])
                begin
                    found             = 1'b1;
                    taken[p]          = 1'b1;
                    pin_used[p]       = 1'b1;
                    pin_slot[p*5 +: 5] = 5'(s);
                end
            end
        end
    end
endmodule
`default_nettype wire

// ---- core/xbar_pin_enables.sv ----
// Operation
// - enable_a bit 7 routes comparator zero output to a pin.
// - enable_a bit 6 gives the counter-array clock input a pin.
// - enable_a bits 5:3 route that many compare outputs, 0..5.
// - enable_a bit 2 puts first UART TX on P0.0, RX on P0.1 when neither pin is skipped.
// - enable_a bit 1 routes SPI SCK, MISO, MOSI, NSS to four pins.
// - enable_a bit 0 routes SMBus SDA and SCL to two pins.
// - enable_b bit 7 drives inverted system clock onto a pin.
// - enable_b bit 6 connects timer two capture input to a pin.
// - enable_b bit 5 connects timer two count input to a pin.
// - enable_b bit 4 gives interrupt one input a pin.
// - enable_b bit 3 connects timer one count input to a pin.
// - enable_b bit 2 gives interrupt zero input a pin.
// - enable_b bit 1 connects timer zero count input to a pin.
// - enable_b bit 0 routes comparator one output to a pin.
// - Enabled functions take next free unskipped pin, from P0.0.
// - Global enable cleared forces all pins of ports 0-3 to input.
// - Port one analog-input pins are never assigned a function.
`default_nettype none
`include "xbar_cfg.svh"
module xbar_pin_enables
    import xbar_pkg::*;
(
    // Clock and reset
    input  wire logic                     mclk,
    input  wire logic                     sys_rst,
    // Special-function register port
    input  wire xbar_sfr_req_t            sfr_req,
    output logic [7:0]                    sfr_rdata,
    output logic                          sfr_hit,
    // Configuration held by the third crossbar register elsewhere
    input  wire logic                     crossbar_global_enable,
    input  wire logic                     uart_two_pin_enable,
    input  wire logic                     timer_four_count_in_enable,
    input  wire logic                     timer_four_capture_in_enable,
    input  wire logic                     convert_start_in_enable,
    input  wire logic [`XBAR_NPINS-1:0]   external_skip,
    input  wire logic [7:0]               port_one_input_mode,
    // Routing result toward the port pins
    output xbar_pinmap_t                  pinmap,
    output logic [`XBAR_NPINS*5-1:0]      pin_function,
    output logic [7:0]                    crossbar_enable_a,
    output logic [7:0]                    crossbar_enable_b
);
    xbar_state_t            state;
    xbar_state_t            next_state;
    logic [`XBAR_NSLOT-1:0] slot_req;
    logic [`XBAR_NPINS-1:0] pin_skip;
    logic [`XBAR_NPINS-1:0] pin_used;
    logic [`XBAR_NPINS*5-1:0] pin_slot;
    logic [2:0]             cex_count;
    logic [1:0]             reg_sel;
    logic [3:0]             third_enables;

    // Address decode shared by read and write paths
    function automatic logic [1:0] decode(input logic [7:0] addr);
        decode = {addr == `XBAR_ADDR_ENABLE_B,
                  addr == `XBAR_ADDR_ENABLE_A};
    endfunction

    // Request of one priority slot from the enables
    function automatic logic slot_wanted(
        input int         slot,
        input logic [7:0] en_a,
        input logic [7:0] en_b,
        input logic [3:0] ext,
        input logic [2:0] cex_n
    );
        logic wanted;
        wanted = 1'b0;
        case (slot)
            `XBAR_SLOT_TX0,
            `XBAR_SLOT_RX0:       wanted = en_a[`XBAR_A_UART_FIRST];
            `XBAR_SLOT_SCK,
            `XBAR_SLOT_MISO,
            `XBAR_SLOT_MOSI,
            `XBAR_SLOT_NSS:       wanted = en_a[`XBAR_A_SPI];
            `XBAR_SLOT_SDA,
            `XBAR_SLOT_SCL:       wanted = en_a[`XBAR_A_SMB];
            // Second UART pair, enabled elsewhere
            `XBAR_SLOT_TX1,
            `XBAR_SLOT_RX1:       wanted = ext[`XBAR_EXT_UART_TWO];
            `XBAR_SLOT_CMP_OUT0:  wanted = cex_n > 3'h0;
            `XBAR_SLOT_CMP_OUT1:  wanted = cex_n > 3'h1;
            `XBAR_SLOT_CMP_OUT2:  wanted = cex_n > 3'h2;
            `XBAR_SLOT_CMP_OUT3:  wanted = cex_n > 3'h3;
            `XBAR_SLOT_CMP_OUT4:  wanted = cex_n > 3'h4;
            `XBAR_SLOT_CNT_CLK:   wanted = en_a[`XBAR_A_CNT_CLK];
            `XBAR_SLOT_CMP_ZERO:  wanted = en_a[`XBAR_A_CMP_ZERO];
            `XBAR_SLOT_CMP_ONE:   wanted = en_b[`XBAR_B_CMP_ONE];
            `XBAR_SLOT_TMR_ZERO:  wanted = en_b[`XBAR_B_TMR_ZERO];
            `XBAR_SLOT_IRQ_ZERO:  wanted = en_b[`XBAR_B_IRQ_ZERO];
            `XBAR_SLOT_TMR_ONE:   wanted = en_b[`XBAR_B_TMR_ONE];
            `XBAR_SLOT_IRQ_ONE:   wanted = en_b[`XBAR_B_IRQ_ONE];
            `XBAR_SLOT_TMR_TWO:   wanted = en_b[`XBAR_B_TMR_TWO];
            `XBAR_SLOT_CAP_TWO:   wanted = en_b[`XBAR_B_CAP_TWO];
            // Timer four pair, enabled elsewhere
            `XBAR_SLOT_TMR_FOUR:  wanted = ext[`XBAR_EXT_TMR_FOUR];
            `XBAR_SLOT_CAP_FOUR:  wanted = ext[`XBAR_EXT_CAP_FOUR];
            `XBAR_SLOT_SYSCK:     wanted = en_b[`XBAR_B_SYSCK];
            // Lowest priority, enabled elsewhere
            `XBAR_SLOT_CNV:       wanted = ext[`XBAR_EXT_CONVERT];
            default:              wanted = 1'b0;
        endcase
        return wanted;
    endfunction

    // Select lines: bit 0 enable_a, bit 1 enable_b
    assign reg_sel = decode(sfr_req.addr);

    always_comb
    begin
        next_state = state;
        if (sfr_req.wr && reg_sel[0])
            next_state.enable_a = sfr_req.wdata;
        if (sfr_req.wr && reg_sel[1])
            next_state.enable_b = sfr_req.wdata;
        // Idle or unmapped reads return zero
        next_state.rdata = 8'h00;
        if (sfr_req.rd)
        begin
            case (reg_sel)
                2'b01:   next_state.rdata = state.enable_a;
                2'b10:   next_state.rdata = state.enable_b;
                default: next_state.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state.enable_a <= `XBAR_RESET_VALUE;
            state.enable_b <= `XBAR_RESET_VALUE;
            state.rdata    <= 8'h00;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign sfr_rdata         = state.rdata;
    assign sfr_hit           = |decode(sfr_req.addr);
    assign crossbar_enable_a = state.enable_a;
    assign crossbar_enable_b = state.enable_b;

    // reserved codes route nothing, a safe fallback
    always_comb
    begin
        cex_count = state.enable_a[`XBAR_A_CEX_HI:`XBAR_A_CEX_LO];
        if (cex_count > `XBAR_CEX_MAX)
        begin
            cex_count = 3'h0;
        end
    end

    assign third_enables = {convert_start_in_enable,
                            timer_four_capture_in_enable,
                            timer_four_count_in_enable,
                            uart_two_pin_enable};

    generate
        for (genvar s = 0; s < `XBAR_NSLOT; s++)
        begin : g_slot
            assign slot_req[s] = slot_wanted(s, state.enable_a,
                                             state.enable_b, third_enables,
                                             cex_count);
        end
    endgenerate

    assign pin_skip = external_skip | {16'h0000, ~port_one_input_mode, 8'h00};

    xbar_alloc u_alloc
    (
        .slot_req (slot_req),
        .pin_skip (pin_skip),
        .pin_slot (pin_slot),
        .pin_used (pin_used)
    );

    always_comb
    begin
        if (crossbar_global_enable)
        begin
            pinmap.assigned    = pin_used;
            pinmap.force_input = '0;
            pin_function       = pin_slot;
        end
        else
        begin
            pinmap.assigned    = '0;
            pinmap.force_input = '1;
            pin_function       = {`XBAR_NPINS{`XBAR_NO_SLOT}};
        end
    end
endmodule
`default_nettype wire

// ---- dv/xbar_port_load.sv ----
`default_nettype none
`include "xbar_cfg.svh"
// Far-side loads: counts pins that carry any function
module xbar_port_load
(
    // Pin functions from the crossbar
    input  wire logic [`XBAR_NPINS*5-1:0] pin_function,
    // Pins seen in use
    output logic [5:0]                    driven_pins
);
    timeunit 1ns;
    timeprecision 1ps;
    always_comb
    begin
        driven_pins = '0;
        for (int p = 0; p < `XBAR_NPINS; p++)
            if (pin_function[p*5 +: 5] != `XBAR_NO_SLOT)
                driven_pins = driven_pins + 6'h1;
    end
endmodule
`default_nettype wire

// ---- dv/xbar_pin_enables_props.sv ----
`default_nettype none
`include "xbar_cfg.svh"
module xbar_pin_enables_props
    import xbar_pkg::*;
(
    // Clock, reset, register port
    input wire logic                  mclk,
    input wire logic                  sys_rst,
    input wire xbar_sfr_req_t         sfr_req,
    input wire logic [7:0]            sfr_rdata,
    input wire logic                  sfr_hit,
    // Routing
    input wire logic                  crossbar_global_enable,
    input wire logic [31:0]           external_skip,
    input wire logic [7:0]            port_one_input_mode,
    input wire xbar_pinmap_t          pinmap,
    input wire logic [159:0]          pin_function,
    input wire logic [7:0]            crossbar_enable_a,
    input wire logic [7:0]            crossbar_enable_b
);
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    logic [7:0] p1_fn;
    logic       w_a;
    logic       w_b;
    assign w_a = sfr_req.wr && sfr_req.addr == `XBAR_ADDR_ENABLE_A;
    assign w_b = sfr_req.wr && sfr_req.addr == `XBAR_ADDR_ENABLE_B;
    always_comb
        for (int n = 0; n < 8; n++)
            p1_fn[n] = pin_function[(8+n)*5 +: 5] != `XBAR_NO_SLOT;
    AST_WR_A: assert property (
        w_a |=> crossbar_enable_a == $past(sfr_req.wdata))
        else $error("enable_a write lost");
    AST_WR_B: assert property (
        w_b |=> crossbar_enable_b == $past(sfr_req.wdata))
        else $error("enable_b write lost");
    AST_HOLD: assert property (
        !(sfr_req.wr && sfr_hit) |=>
        $stable(crossbar_enable_a) && $stable(crossbar_enable_b))
        else $error("register changed without write");
    AST_RD_B: assert property (
        sfr_req.rd && !sfr_req.wr && sfr_req.addr == `XBAR_ADDR_ENABLE_B
        |=> sfr_rdata == crossbar_enable_b)
        else $error("enable_b readback wrong");
    AST_RD_NONE: assert property (
        sfr_req.rd && !sfr_hit |=> sfr_rdata == 8'h00)
        else $error("unmapped read not zero");
    AST_UART: assert property (
        crossbar_global_enable && crossbar_enable_a[2] &&
        external_skip[1:0] == 2'b00
        |-> pin_function[9:0] == {5'h01, 5'h00})
        else $error("uart not on first pins");
    AST_SPI: assert property (
        crossbar_global_enable &&
        crossbar_enable_a == 8'h02 && external_skip == '0
        |-> pin_function[19:0] == {5'h05, 5'h04, 5'h03, 5'h02})
        else $error("spi pins wrong");
    AST_SMB: assert property (
        crossbar_global_enable &&
        crossbar_enable_a == 8'h01 && external_skip == '0
        |-> pin_function[9:0] == {5'h07, 5'h06})
        else $error("smbus pins wrong");
    AST_OFF: assert property (
        !crossbar_global_enable |-> pinmap.force_input == '1)
        else $error("pins not inputs while disabled");
    AST_ANALOG: assert property (
        (p1_fn & ~port_one_input_mode) == 8'h00)
        else $error("analog pin given a function");
    cover property (w_a ##2 w_b);
    cover property (sfr_req.rd && !sfr_hit);
    cover property (crossbar_enable_a[5:3] == 3'h5);
endmodule
`default_nettype wire

// ---- dv/xbar_pin_enables_tb_top.sv ----
`default_nettype none
`include "xbar_cfg.svh"
module xbar_pin_enables_tb_top
    import xbar_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic          mclk = 1'b0;
    logic          sys_rst = 1'b1;
    xbar_sfr_req_t req = '0;
    logic [7:0]    rdata;
    logic          hit;
    // {global, uart two, timer four, timer four capture, convert}
    logic [4:0]    third = 5'h10;
    logic [31:0]   skip = '0;
    logic [7:0]    p1mode = 8'hff;
    xbar_pinmap_t  pmap;
    logic [159:0]  pfunc;
    logic [7:0]    ena;
    logic [7:0]    enb;
    logic [5:0]    driven;
    int            mismatches = 0;
    int            checks = 0;
    int            cycles = 0;
    always #20 mclk = ~mclk;
    xbar_pin_enables uut (.mclk(mclk), .sys_rst(sys_rst), .sfr_req(req),
        .sfr_rdata(rdata), .sfr_hit(hit), .crossbar_global_enable(third[4]),
        .uart_two_pin_enable(third[3]), .timer_four_count_in_enable(third[2]),
        .timer_four_capture_in_enable(third[1]),
        .convert_start_in_enable(third[0]), .external_skip(skip),
        .port_one_input_mode(p1mode), .pinmap(pmap), .pin_function(pfunc),
        .crossbar_enable_a(ena), .crossbar_enable_b(enb));
    xbar_port_load load (.pin_function(pfunc), .driven_pins(driven));
    task automatic check(input logic [159:0] seen, input logic [159:0] exp);
        checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        $display("Checks %0d, mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic sfr(input logic w, input logic [7:0] a,
                       input logic [7:0] d);
        @(negedge mclk);
        req = '{wr: w, rd: !w, addr: a, wdata: d};
        @(negedge mclk);
        req = '0;
    endtask
    function automatic logic [159:0] exp_map(input logic [7:0] a,
                                             input logic [7:0] b);
        logic [27:0] r;
        logic [31:0] s;
        int          p;
        exp_map = {32{5'h1f}};
        r = {third[0], b[7], third[1], third[2], b[6:0], a[7:6], 5'h00,
             {2{third[3]}}, {2{a[0]}}, {4{a[1]}}, {2{a[2]}}};
        if (a[5:3] <= 3'h5)
            r[14:10] = ~(5'h1f << a[5:3]);
        s = skip | {16'h0, ~p1mode, 8'h0};
        p = 0;
        for (int i = 0; i < 28; i++)
            if (r[i])
            begin
                while (p < 32 && s[p])
                    p++;
                if (p < 32)
                    exp_map[p*5 +: 5] = 5'(i);
                p++;
            end
    endfunction
    task automatic apply(input logic [7:0] a, input logic [7:0] b);
        logic [159:0] m;
        int           n;
        m = exp_map(a, b);
        n = 0;
        sfr(1'b1, `XBAR_ADDR_ENABLE_A, a);
        sfr(1'b1, `XBAR_ADDR_ENABLE_B, b);
        check(pfunc, m);
        for (int p = 0; p < 32; p++)
            n += (m[p*5 +: 5] != 5'h1f);
        check(driven, 6'(n));
        sfr(1'b0, `XBAR_ADDR_ENABLE_A, 8'h00);
        check(rdata, a);
        sfr(1'b0, `XBAR_ADDR_ENABLE_B, 8'h00);
        check(rdata, b);
    endtask
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            mismatches++;
            test_done();
        end
    end
    initial
    begin
        repeat (3) @(negedge mclk);
        sys_rst = 1'b0;
        check({ena, enb}, 16'h0);
        check(pfunc, {32{5'h1f}});
        sfr(1'b0, 8'he3, 8'h00);
        check(rdata, 8'h00);
        $display("Reset test done");
        for (int i = 0; i < 16; i++)
            apply(8'(16'h1 << i), 8'((16'h1 << i) >> 8));
        $display("Single enable test done");
        // only codes 000 to 101 written
        for (int c = 0; c < 6; c++)
            apply(8'(c << 3), 8'h00);
        $display("Compare count test done");
        third = 5'h18;
        skip = 32'he0;
        p1mode = 8'he3;
        apply(8'h05, 8'h14);
        check(pfunc[13*5 +: 5], 5'h15);
        third = 5'h1f;
        apply(8'hef, 8'hff);
        sfr(1'b1, 8'he0, 8'h00);
        check({ena, enb}, 16'hefff);
        third = 5'h0f;
        @(negedge mclk);
        check(pmap.force_input, 32'hffffffff);
        check(pmap.assigned, 32'h0);
        check(pfunc, {32{5'h1f}});
        $display("Priority and disable test done");
        test_done();
    end
endmodule
bind xbar_pin_enables xbar_pin_enables_props props (.mclk, .sys_rst,
    .sfr_req, .sfr_rdata, .sfr_hit, .crossbar_global_enable, .external_skip,
    .port_one_input_mode, .pinmap, .pin_function, .crossbar_enable_a,
    .crossbar_enable_b);
`default_nettype wire
